// >>> design/bss_pkg.sv
// constants for the bit sync supervisor
package bss_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // times in their own units, cycle counts derived
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned LOCK_TMO_MS = 2000;
  localparam int unsigned LOCK_TMO_CYC = CLK_HZ / 1000 * LOCK_TMO_MS;
  localparam int unsigned CARD_RST_US = 100;
  localparam int unsigned CARD_RST_CYC = CLK_HZ / 1_000_000 * CARD_RST_US;
  localparam int unsigned PWR_OFF_MS = 500;
  localparam int unsigned PWR_OFF_CYC = CLK_HZ / 1000 * PWR_OFF_MS;
  localparam int unsigned RATE_WIN_MS = 4;
  localparam int unsigned RATE_WIN_CYC = CLK_HZ / 1000 * RATE_WIN_MS;

  localparam int unsigned RATE_EDGE_THR = 32;
  localparam int unsigned MAX_RESETS = 3;
  localparam int unsigned MAX_PWR = 2;
  localparam int unsigned LOCK_MISSES = 2;

  // card configuration byte
  localparam int unsigned CFG_RATE_BIT = 0;
  localparam int unsigned CFG_INV_BIT = 1;
  localparam logic AUTO_RATE_RST = 1'b1;

  // debounced switch index
  localparam int unsigned SW_HI = 0;
  localparam int unsigned SW_LO = 1;
  localparam int unsigned SW_INV = 2;
  localparam int unsigned SW_WD = 3;
  localparam int unsigned SW_BTN = 4;
  localparam int unsigned SW_N = 5;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_COUNTS = 8'h10;
  localparam logic [7:0] REG_CARD_CFG = 8'h14;
  localparam int unsigned IRQ_W = 5;

  typedef enum logic [4:0] {
    WD_IDLE = 5'h01,
    WD_WAIT = 5'h02,
    WD_RESET = 5'h04,
    WD_POWER = 5'h08,
    WD_ERROR = 5'h10
  } bss_wd_t;

endpackage : bss_pkg

// >>> design/bss_supervisor.sv
// bit sync supervisor: switches, card config, frame search, watchdog, regs
////////////////////////////////////////////////////////////////////////////////
// Contract
// - write the card config after power-up and on every operator switch request.
// - fixed rate switch programs 32 kbps when high and 4 kbps when low.
// - centre position samples input rate after frame lock loss and programs it.
// - mismatch led lights while sampled rate differs from programmed rate.
// - search card output for the frame header, frame led lit while locked.
// - bit lock led lit while the card reports bit lock; the code also holds it off while card_power_en is low.
// - polarity switch selects normal or inverted card output.
// - watchdog recovery only while the watchdog switch is on.
// - binary count of watchdog card resets, cleared by any reset.
// - binary count of card power cycles, cleared by any reset.
// - error led lit when watchdog recovery cannot clear out-of-lock.
// - the front panel button soft resets the controller.
// - red leds for signal loss, overload and offset.
////////////////////////////////////////////////////////////////////////////////
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
module bss_supervisor #(
  parameter int unsigned DEBOUNCE_CYC = bss_pkg::DEBOUNCE_CYC,
  parameter int unsigned LOCK_TMO_CYC = bss_pkg::LOCK_TMO_CYC,
  parameter int unsigned PWR_OFF_CYC = bss_pkg::PWR_OFF_CYC,
  parameter int unsigned RATE_WIN_CYC = bss_pkg::RATE_WIN_CYC,
  parameter int unsigned CARD_RST_CYC = bss_pkg::CARD_RST_CYC,
  parameter int unsigned MAX_RESETS = bss_pkg::MAX_RESETS,
  parameter int unsigned MAX_PWR = bss_pkg::MAX_PWR,
  parameter int unsigned CNT_W = 4,
  parameter int unsigned HDR_W = 16,
  parameter logic [HDR_W-1:0] HDR_PATTERN = 16'h1D2B,
  parameter int unsigned FRAME_BITS = 512
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic irq,
  input wire logic rate_high_select,
  input wire logic rate_low_select,
  input wire logic sw_pol_inv,
  input wire logic sw_wd_en,
  input wire logic btn_reset,
  input wire logic in_data,
  input wire logic card_dclk,
  input wire logic card_data,
  input wire logic card_bit_lock,
  input wire logic card_loss,
  input wire logic card_overload,
  input wire logic card_offset,
  output logic card_wr,
  output logic [7:0] card_wdata,
  output logic card_reset,
  output logic card_power_en,
  output logic led_bit_lock,
  output logic led_frame_lock,
  output logic led_rate_mismatch,
  output logic led_error,
  output logic [CNT_W-1:0] led_reset_count,
  output logic [CNT_W-1:0] led_pwr_count,
  output logic led_loss,
  output logic led_overload,
  output logic led_offset
);

  localparam int unsigned DB_W = $clog2(DEBOUNCE_CYC + 1);
  localparam int unsigned RI = bss_pkg::CFG_RATE_BIT;

  if (CNT_W < 1 || CNT_W > 8 || HDR_W < 2 || FRAME_BITS <= HDR_W || FRAME_BITS > 65535
      || DEBOUNCE_CYC < 1 || MAX_RESETS > 255 || MAX_PWR > 255 || CARD_RST_CYC < 1
      || PWR_OFF_CYC < 1 || LOCK_TMO_CYC < 1 || RATE_WIN_CYC < 2) begin : g_bad
    $error("bss_supervisor: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // switch synchronise and debounce
  logic [bss_pkg::SW_N-1:0] sw_raw, sync1_r, sync2_r, db_r, db_nxt;
  logic sw_chg, soft_rst;

  assign sw_raw = {btn_reset, sw_wd_en, sw_pol_inv, rate_low_select, rate_high_select};

  for (genvar i = 0; i < bss_pkg::SW_N; i++) begin : g_db
    logic [DB_W-1:0] cnt_r, cnt_nxt;
    logic bit_nxt;
    always_comb begin
      cnt_nxt = '0;
      bit_nxt = db_r[i];
      if (sync2_r[i] != db_r[i]) begin
        cnt_nxt = cnt_r + 1'b1;
        // a change must hold a full debounce time
        if (cnt_r == DB_W'(DEBOUNCE_CYC - 1)) begin
          bit_nxt = sync2_r[i];
          cnt_nxt = '0;
        end
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
    assign db_nxt[i] = bit_nxt;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      db_r <= '0;
    end else begin
      sync1_r <= sw_raw;
      sync2_r <= sync1_r;
      db_r <= db_nxt;
    end
  end

  // operator request: any debounced change of rate or polarity switch
  assign sw_chg = (db_nxt[bss_pkg::SW_INV:0] != db_r[bss_pkg::SW_INV:0]);
  assign soft_rst = db_nxt[bss_pkg::SW_BTN] && !db_r[bss_pkg::SW_BTN];

  ////////////////////////////////////////////////////////////////////////////////
  // frame header search and input rate sampling
  logic [HDR_W-1:0] hdr_sh_r, hdr_sh_nxt, hdr_want;
  logic [15:0] fbit_r, fbit_nxt, edges_r, edges_nxt;
  logic [1:0] miss_r, miss_nxt;
  logic flock_r, flock_nxt, dclk_q_r, din_q_r, win_end;
  logic [31:0] win_r, win_nxt;
  logic meas_hi_r, meas_hi_nxt, meas_ok_r, meas_ok_nxt;
  logic [7:0] card_cfg_r;

  always_comb begin
    // inverted output carries the inverted header
    hdr_want = HDR_PATTERN ^ {HDR_W{card_cfg_r[bss_pkg::CFG_INV_BIT]}};
    hdr_sh_nxt = hdr_sh_r;
    fbit_nxt = fbit_r;
    miss_nxt = miss_r;
    flock_nxt = flock_r;
    if (card_dclk && !dclk_q_r) begin
      hdr_sh_nxt = {hdr_sh_r[HDR_W-2:0], card_data};
      fbit_nxt = fbit_r + 16'h0001;
      if (!flock_r) begin
        if (hdr_sh_nxt == hdr_want) begin
          flock_nxt = 1'b1;
          fbit_nxt = '0;
          miss_nxt = '0;
        end
      end else if (fbit_r == 16'(FRAME_BITS - 1)) begin
        fbit_nxt = '0;
        if (hdr_sh_nxt == hdr_want) begin
          miss_nxt = '0;
        end else if (miss_r == 2'(bss_pkg::LOCK_MISSES - 1)) begin
          flock_nxt = 1'b0; // one bad header is tolerated, not two
          miss_nxt = '0;
        end else begin
          miss_nxt = miss_r + 2'h1;
        end
      end
    end
    if (card_reset || !card_power_en) begin
      flock_nxt = 1'b0;
    end
    win_end = (win_r == 32'(RATE_WIN_CYC - 1));
    win_nxt = win_end ? '0 : win_r + 32'h0000_0001;
    edges_nxt = edges_r;
    if (win_end) begin
      edges_nxt = '0;
    end else if (in_data != din_q_r && edges_r != 16'hFFFF) begin
      edges_nxt = edges_r + 16'h0001;
    end
    // transitions per window separate the two rates
    meas_hi_nxt = win_end ? (edges_r >= 16'(bss_pkg::RATE_EDGE_THR)) : meas_hi_r;
    meas_ok_nxt = meas_ok_r || win_end;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hdr_sh_r <= '0;
      fbit_r <= '0;
      miss_r <= '0;
      flock_r <= 1'b0;
      dclk_q_r <= 1'b0;
      din_q_r <= 1'b0;
      win_r <= '0;
      edges_r <= '0;
      meas_hi_r <= 1'b0;
      meas_ok_r <= 1'b0;
    end else begin
      hdr_sh_r <= hdr_sh_nxt;
      fbit_r <= fbit_nxt;
      miss_r <= miss_nxt;
      flock_r <= flock_nxt;
      dclk_q_r <= card_dclk;
      din_q_r <= in_data;
      win_r <= win_nxt;
      edges_r <= edges_nxt;
      meas_hi_r <= meas_hi_nxt;
      meas_ok_r <= meas_ok_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // card configuration and watchdog
  bss_pkg::bss_wd_t wd_r, wd_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [7:0] att_rst_r, att_rst_nxt, att_pwr_r, att_pwr_nxt, cfg_nxt, want_cfg;
  logic [CNT_W-1:0] rst_cnt_r, rst_cnt_nxt, pwr_cnt_r, pwr_cnt_nxt;
  logic auto_r, auto_nxt, pend_r, pend_nxt, wr_nxt, refresh, wd_en, ool, reconf;

  always_comb begin
    wd_en = db_r[bss_pkg::SW_WD];
    ool = !flock_r;
    want_cfg = '0;
    want_cfg[RI] = db_r[bss_pkg::SW_HI] ? 1'b1 : db_r[bss_pkg::SW_LO] ? 1'b0 : auto_r;
    want_cfg[bss_pkg::CFG_INV_BIT] = db_r[bss_pkg::SW_INV];
    auto_nxt = auto_r;
    if (!db_r[bss_pkg::SW_HI] && !db_r[bss_pkg::SW_LO] && ool && win_end) begin
      auto_nxt = meas_hi_nxt;
    end
    wd_nxt = wd_r;
    tmr_nxt = tmr_r + 32'h0000_0001;
    att_rst_nxt = att_rst_r;
    att_pwr_nxt = att_pwr_r;
    rst_cnt_nxt = rst_cnt_r;
    pwr_cnt_nxt = pwr_cnt_r;
    refresh = 1'b0;
    unique case (wd_r)
      bss_pkg::WD_IDLE: begin
        tmr_nxt = '0;
        att_rst_nxt = '0;
        att_pwr_nxt = '0;
        if (wd_en && ool) wd_nxt = bss_pkg::WD_WAIT;
      end
      bss_pkg::WD_WAIT: begin
        if (!wd_en || !ool) begin
          wd_nxt = bss_pkg::WD_IDLE;
        end else if (tmr_r == 32'(LOCK_TMO_CYC - 1)) begin
          tmr_nxt = '0;
          if (att_rst_r < 8'(MAX_RESETS)) begin
            wd_nxt = bss_pkg::WD_RESET;
            att_rst_nxt = att_rst_r + 8'h01;
            rst_cnt_nxt = rst_cnt_r + 1'b1;
          end else if (att_pwr_r < 8'(MAX_PWR)) begin
            wd_nxt = bss_pkg::WD_POWER;
            att_pwr_nxt = att_pwr_r + 8'h01;
            pwr_cnt_nxt = pwr_cnt_r + 1'b1;
          end else begin
            wd_nxt = bss_pkg::WD_ERROR;
          end
        end
      end
      bss_pkg::WD_RESET: begin
        // switching the watchdog off cuts a recovery short
        if (!wd_en || tmr_r == 32'(CARD_RST_CYC - 1)) begin
          wd_nxt = bss_pkg::WD_WAIT;
          tmr_nxt = '0;
          refresh = 1'b1;
        end
      end
      bss_pkg::WD_POWER: begin
        if (!wd_en || tmr_r == 32'(PWR_OFF_CYC - 1)) begin
          wd_nxt = bss_pkg::WD_WAIT;
          tmr_nxt = '0;
          refresh = 1'b1;
        end
      end
      bss_pkg::WD_ERROR: begin
        tmr_nxt = '0;
        if (!wd_en || !ool) wd_nxt = bss_pkg::WD_IDLE;
      end
    endcase
    // card loses its setup in reset or power off, so hold writes off
    wr_nxt = pend_r && wd_r != bss_pkg::WD_RESET && wd_r != bss_pkg::WD_POWER;
    cfg_nxt = wr_nxt ? want_cfg : card_cfg_r;
    pend_nxt = (pend_r && !wr_nxt) || sw_chg || refresh || reconf
               || (want_cfg != cfg_nxt);
    if (soft_rst) begin
      wd_nxt = bss_pkg::WD_IDLE;
      tmr_nxt = '0;
      rst_cnt_nxt = '0;
      pwr_cnt_nxt = '0;
      auto_nxt = bss_pkg::AUTO_RATE_RST;
      pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_r <= bss_pkg::WD_IDLE;
      tmr_r <= '0;
      att_rst_r <= '0;
      att_pwr_r <= '0;
      rst_cnt_r <= '0;
      pwr_cnt_r <= '0;
      auto_r <= bss_pkg::AUTO_RATE_RST;
      pend_r <= 1'b1; // power-up write
      card_wr <= 1'b0;
      card_cfg_r <= '0;
      card_reset <= 1'b0;
      card_power_en <= 1'b1;
    end else begin
      wd_r <= wd_nxt;
      tmr_r <= tmr_nxt;
      att_rst_r <= att_rst_nxt;
      att_pwr_r <= att_pwr_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
      auto_r <= auto_nxt;
      pend_r <= pend_nxt;
      card_wr <= wr_nxt;
      card_cfg_r <= cfg_nxt;
      card_reset <= (wd_nxt == bss_pkg::WD_RESET);
      card_power_en <= (wd_nxt != bss_pkg::WD_POWER);
    end
  end

  assign card_wdata = card_cfg_r;
  assign led_frame_lock = flock_r;
  assign led_error = wd_r[4];
  assign led_reset_count = rst_cnt_r;
  assign led_pwr_count = pwr_cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // panel leds, interrupts and wishbone slave
  logic [bss_pkg::IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic [31:0] rd_nxt;
  logic hit, wr, bit_nxt, mis_nxt;

  always_comb begin
    bit_nxt = card_bit_lock && card_power_en;
    mis_nxt = meas_ok_r && (meas_hi_r != card_cfg_r[RI]);
    ev = {wd_nxt == bss_pkg::WD_ERROR && wd_r != bss_pkg::WD_ERROR,
          wd_nxt == bss_pkg::WD_POWER && wd_r != bss_pkg::WD_POWER,
          wd_nxt == bss_pkg::WD_RESET && wd_r != bss_pkg::WD_RESET,
          led_bit_lock && !bit_nxt,
          flock_r && !flock_nxt};
    hit = wb_cyc && wb_stb && !wb_ack;
    wr = hit && wb_we && wb_sel[0];
    reconf = wr && wb_adr == bss_pkg::REG_CTRL && wb_dat_w[0];
    mask_nxt = (wr && wb_adr == bss_pkg::REG_IRQ_MASK) ? wb_dat_w[bss_pkg::IRQ_W-1:0] : mask_r;
    stat_nxt = stat_r;
    if (wr && wb_adr == bss_pkg::REG_IRQ_STAT) begin
      stat_nxt = stat_r & ~wb_dat_w[bss_pkg::IRQ_W-1:0];
    end
    // an event in the clearing cycle survives
    stat_nxt = (soft_rst ? '0 : stat_nxt) | ev;
    rd_nxt = '0;
    if (hit && !wb_we) begin
      unique case (wb_adr)
        bss_pkg::REG_STATUS: rd_nxt[10:0] = {led_offset, led_overload, led_loss,
                                             !card_power_en, led_error, meas_ok_r,
                                             meas_hi_r, !db_r[0] && !db_r[1],
                                             led_rate_mismatch, flock_r, led_bit_lock};
        bss_pkg::REG_IRQ_STAT: rd_nxt[bss_pkg::IRQ_W-1:0] = stat_r;
        bss_pkg::REG_IRQ_MASK: rd_nxt[bss_pkg::IRQ_W-1:0] = mask_r;
        bss_pkg::REG_COUNTS: rd_nxt[15:0] = {8'(pwr_cnt_r), 8'(rst_cnt_r)};
        bss_pkg::REG_CARD_CFG: rd_nxt[7:0] = card_cfg_r;
        default: rd_nxt = '0; // control and unmapped read zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      led_bit_lock <= 1'b0;
      led_rate_mismatch <= 1'b0;
      led_loss <= 1'b0;
      led_overload <= 1'b0;
      led_offset <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
      wb_ack <= 1'b0;
      wb_dat_r <= '0;
    end else begin
      led_bit_lock <= bit_nxt;
      led_rate_mismatch <= mis_nxt;
      led_loss <= card_loss;
      led_overload <= card_overload;
      led_offset <= card_offset;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      wb_ack <= hit;
      wb_dat_r <= rd_nxt;
    end
  end

  assign irq = |(stat_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_fixed_rate;
    @(posedge clk) disable iff (!reset_n)
    card_wr && ($past(db_r[0]) || $past(db_r[1])) |-> card_wdata[RI] == $past(db_r[0]);
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate not programmed");

  property p_polarity;
    @(posedge clk) disable iff (!reset_n)
    card_wr |-> card_wdata[bss_pkg::CFG_INV_BIT] == $past(db_r[bss_pkg::SW_INV]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not programmed");

  property p_sw_write;
    @(posedge clk) disable iff (!reset_n)
    sw_chg && !soft_rst && !db_r[bss_pkg::SW_WD] |-> ##[1:3] card_wr;
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("switch change not written");

  property p_wd_inhibit;
    @(posedge clk) disable iff (!reset_n)
    $rose(card_reset) || $fell(card_power_en) |-> $past(db_r[bss_pkg::SW_WD]);
  endproperty
  a_wd_inhibit: assert property (p_wd_inhibit) else $error("recovery while disabled");

  property p_rst_count;
    @(posedge clk) disable iff (!reset_n)
    $rose(card_reset) |-> led_reset_count == CNT_W'($past(led_reset_count) + 1'b1);
  endproperty
  a_rst_count: assert property (p_rst_count) else $error("reset count wrong");

  property p_pwr_count;
    @(posedge clk) disable iff (!reset_n)
    $fell(card_power_en) |-> led_pwr_count == CNT_W'($past(led_pwr_count) + 1'b1);
  endproperty
  a_pwr_count: assert property (p_pwr_count) else $error("power count wrong");

  property p_escalate;
    @(posedge clk) disable iff (!reset_n)
    $rose(led_error) |-> att_rst_r == 8'(MAX_RESETS) && att_pwr_r == 8'(MAX_PWR);
  endproperty
  a_escalate: assert property (p_escalate) else $error("error before escalation");

  property p_soft_reset;
    @(posedge clk) disable iff (!reset_n)
    soft_rst |=> led_reset_count == '0 && led_pwr_count == '0 && !led_error ##1 card_wr;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_frame_lock;
    @(posedge clk) disable iff (!reset_n)
    $rose(led_frame_lock) |-> hdr_sh_r == $past(hdr_want);
  endproperty
  a_frame_lock: assert property (p_frame_lock) else $error("lock without header");

  property p_debounce;
    @(posedge clk) disable iff (!reset_n)
    db_r != $past(db_r) |-> $past(sync2_r, 2) == db_r;
  endproperty
  a_debounce: assert property (p_debounce) else $error("undebounced change");

endmodule : bss_supervisor

// >>> dv/bss_card_model.sv
// behavioural model of the synchronizer card behind the supervisor
module bss_card_model #(
  parameter int unsigned FRAME_BITS = 64,
  parameter logic [15:0] HDR = 16'h1D2B
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic card_wr,
  input wire logic [7:0] card_wdata,
  input wire logic card_reset,
  input wire logic card_power_en,
  input wire logic sig_ok,
  output logic card_dclk,
  output logic card_data,
  output logic card_bit_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg_r;
  logic [2:0] div_r;
  logic [6:0] bit_r;
  logic alive;
  assign alive = card_power_en && !card_reset && sig_ok;
  assign card_bit_lock = alive;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {cfg_r, div_r, bit_r, card_dclk, card_data} <= '0;
    end else begin
      if (card_wr) begin
        cfg_r <= card_wdata;
      end else if (!card_power_en) begin
        cfg_r <= '0;
      end
      if (!card_power_en || card_reset) begin
        // clock stands while held in reset or unpowered
        card_dclk <= 1'h0;
        card_data <= ~card_data;
      end else begin
        div_r <= div_r + 3'h1;
        card_dclk <= div_r[2];
        if (div_r == 3'h3) begin
          bit_r <= (bit_r == FRAME_BITS - 1) ? 7'h0 : bit_r + 7'h1;
          // no signal: clock free-runs on alternating bits, never a header
          card_data <= !sig_ok ? ~card_data
                     : ((bit_r < 16) ? HDR[15 - bit_r] : 1'h0) ^ cfg_r[1];
        end
      end
    end
  end
endmodule : bss_card_model

// >>> dv/tb_top.sv
// self-checking bench for the bit sync supervisor
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, wb_cyc, wb_stb, wb_we, rate_high_select, rate_low_select, sw_pol_inv;
  logic sw_wd_en, btn_reset, in_data, card_loss, card_overload, card_offset, sig_ok;
  logic [7:0] wb_adr, card_wdata;
  logic [3:0] wb_sel, led_reset_count, led_pwr_count;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic wb_ack, irq, card_dclk, card_data, card_bit_lock, card_wr, card_reset, card_power_en;
  logic led_bit_lock, led_frame_lock, led_rate_mismatch, led_error, led_loss, led_overload;
  logic led_offset;
  int miscompares, checks, n, tg, half, rst_edges, pwr_edges, rst_w, pwr_w;
  // {high, low, invert} switches beside the config byte they must produce
  localparam logic [10:0] ROWS [4] = '{11'h401, 11'h200, 11'h302, 11'h503};

  bss_supervisor #(.DEBOUNCE_CYC(4), .LOCK_TMO_CYC(200), .PWR_OFF_CYC(20), .RATE_WIN_CYC(400),
    .FRAME_BITS(64)) dut_u (
    .clk, .reset_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack,
    .irq, .rate_high_select, .rate_low_select, .sw_pol_inv, .sw_wd_en, .btn_reset, .in_data,
    .card_dclk, .card_data, .card_bit_lock, .card_loss, .card_overload, .card_offset, .card_wr,
    .card_wdata, .card_reset, .card_power_en, .led_bit_lock, .led_frame_lock,
    .led_rate_mismatch, .led_error, .led_reset_count, .led_pwr_count, .led_loss,
    .led_overload, .led_offset);
  bss_card_model card_u (.clk, .reset_n, .card_wr, .card_wdata, .card_reset, .card_power_en,
    .sig_ok, .card_dclk, .card_data, .card_bit_lock);

  always #25 clk = ~clk;
  // half sets the input toggle rate: 0 is fast, 39 is slow
  always @(posedge clk) begin
    if (tg >= half) begin
      tg <= 0;
      in_data <= ~in_data;
    end else begin
      tg <= tg + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask : idle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel = 4'hf);
    int k;
    @(posedge clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} <= {2'h3, we, adr, dat, sel};
    // ack and read data are taken at the rising edge, request held until then
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'h1 && k < 20);
    check("wb ack", 32'h1, wb_ack);
    rd = wb_dat_r;
    {wb_cyc, wb_stb} <= 2'h0;
  endtask : wb
  task automatic wait_wr();
    @(negedge clk);
    for (n = 1; n < 400 && card_wr !== 1'h1; n++) @(negedge clk);
    check("card write seen", 32'h1, card_wr);
  endtask : wait_wr
  // pulse widths and order of recovery actions, sampled off the design's edge
  always @(negedge clk) begin
    if (card_reset === 1'h1) rst_w++;
    else if (rst_w != 0) begin
      check("reset width", bss_pkg::CARD_RST_CYC, rst_w);
      rst_edges++;
      rst_w = 0;
    end
    if (card_power_en === 1'h0) pwr_w++;
    else if (pwr_w != 0) begin
      check("power off width", 32'h14, pwr_w);
      check("resets before power", 32'h3, rst_edges);
      pwr_edges++;
      pwr_w = 0;
    end
  end
  initial begin
    #2_000_000;
    miscompares++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, reset_n, wb_cyc, wb_stb, wb_we, rate_high_select, rate_low_select} = '0;
    {sw_pol_inv, sw_wd_en, btn_reset, in_data, card_loss, card_overload, card_offset} = '0;
    {sig_ok, wb_adr, wb_sel, wb_dat_w} = '0;
    idle(5);
    check("outputs in reset", 32'h1, {card_wr, card_reset, led_error, irq, card_power_en});
    check("counts in reset", 32'h0, {led_reset_count, led_pwr_count});
    @(posedge clk);
    reset_n <= 1'h1;
    wait_wr();
    check("power-up config", 32'h1, card_wdata);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {rate_high_select, rate_low_select, sw_pol_inv} <= ROWS[i][10:8];
      wait_wr();
      check("debounce floor", 32'h1, n > 4);
      check("switch config", ROWS[i][7:0], card_wdata);
    end
    $display("test switch table done");
    wb(1'h1, bss_pkg::REG_CTRL, 32'h0000_0001);
    wait_wr();
    check("forced write", 32'h103, {n < 5, card_wdata});
    wb(1'h1, bss_pkg::REG_IRQ_MASK, 32'h0000_0004);
    wb(1'h0, bss_pkg::REG_IRQ_MASK, 32'h0);
    check("mask readback", 32'h4, rd);
    // low byte lane off: the write must be ignored
    wb(1'h1, bss_pkg::REG_IRQ_MASK, 32'h0000_001F, 4'he);
    wb(1'h0, bss_pkg::REG_IRQ_MASK, 32'h0);
    check("mask lane ignored", 32'h4, rd);
    wb(1'h0, 8'h20, 32'h0);
    check("unmapped read", 32'h0, rd);
    wb(1'h0, bss_pkg::REG_COUNTS, 32'h0);
    check("counts after reset", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {card_loss, card_overload, card_offset} <= 3'h1 << i;
      idle(3);
      check("signal leds", 32'h1 << i, {led_loss, led_overload, led_offset});
    end
    $display("test diagnostics done");
    @(posedge clk);
    sig_ok <= 1'h1;
    for (n = 0; n < 3000 && led_frame_lock !== 1'h1; n++) @(negedge clk);
    check("frame lock", 32'h1, led_frame_lock);
    check("bit lock", 32'h1, led_bit_lock);
    idle(1100);
    wb(1'h0, bss_pkg::REG_STATUS, 32'h0);
    check("lock held", 32'h3, rd[1:0]);
    @(posedge clk);
    sig_ok <= 1'h0;
    for (n = 0; n < 1500 && led_frame_lock !== 1'h0; n++) @(negedge clk);
    check("lock lost", 32'h0, {led_frame_lock, led_bit_lock});
    $display("test frame lock done");
    half = 39;
    for (n = 0; n < 1000 && led_rate_mismatch !== 1'h1; n++) @(negedge clk);
    check("mismatch on", 32'h1, led_rate_mismatch);
    half = 0;
    for (n = 0; n < 1000 && led_rate_mismatch !== 1'h0; n++) @(negedge clk);
    check("mismatch off", 32'h0, led_rate_mismatch);
    @(posedge clk);
    {rate_high_select, rate_low_select} <= 2'h0;
    half = 39;
    for (n = 0; n < 1500 && card_wdata[0] !== 1'h0; n++) @(negedge clk);
    check("auto low rate", 32'h2, card_wdata);
    half = 0;
    for (n = 0; n < 1500 && card_wdata[0] !== 1'h1; n++) @(negedge clk);
    check("auto high rate", 32'h3, card_wdata);
    wb(1'h0, bss_pkg::REG_CARD_CFG, 32'h0);
    check("cfg readback", 32'h3, rd);
    $display("test rate done");
    check("no reset while disabled", 32'h0, rst_edges + pwr_edges);
    @(posedge clk);
    sw_wd_en <= 1'h1;
    for (n = 0; n < 8000 && led_error !== 1'h1; n++) @(negedge clk);
    check("error led", 32'h1, led_error);
    check("actions", 32'h32, {rst_edges[3:0], pwr_edges[3:0]});
    check("count leds", 32'h32, {led_reset_count, led_pwr_count});
    wb(1'h0, bss_pkg::REG_COUNTS, 32'h0);
    check("counts reg", 32'h0000_0203, rd);
    check("irq raised", 32'h1, irq);
    wb(1'h1, bss_pkg::REG_IRQ_MASK, 32'h0);
    idle(2);
    check("irq masked", 32'h0, irq);
    wb(1'h1, bss_pkg::REG_IRQ_MASK, 32'h0000_0004);
    idle(2);
    check("irq unmasked", 32'h1, irq);
    wb(1'h1, bss_pkg::REG_IRQ_STAT, 32'h0000_001F);
    idle(2);
    check("irq cleared", 32'h0, irq);
    $display("test watchdog done");
    @(posedge clk);
    btn_reset <= 1'h1;
    idle(10);
    @(posedge clk);
    btn_reset <= 1'h0;
    idle(5);
    check("soft reset", 32'h0, {led_error, led_reset_count, led_pwr_count});
    @(posedge clk);
    sw_wd_en <= 1'h0;
    idle(600);
    check("inhibited", 32'h5, rst_edges + pwr_edges);
    $display("test soft reset done");
    complete_run();
  end
endmodule : tb_top
